// *** rtl/sec_sense_handler.sv ***
// Security command interpreter and extended error encoder with AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "sec_sense_cfg.svh"
module sec_sense_handler
	import sec_sense_pkg::*;
(
	input  wire logic        aclk,          // 10 MHz clock
	input  wire logic        aresetn,       // Sync reset, active low
	input  wire logic        ce,            // Clock enable
	input  wire logic        sec_supported, // Security feature set present
	input  wire logic [31:0] s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [31:0] s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read response valid
	input  wire logic        s_axi_rready,  // Read response ready
	output logic             wear_level_go  // Wear level pulse
);
	// Write channel capture
	logic             aw_held_reg;
	logic [7:0]       aw_addr_reg;
	logic             w_held_reg;
	logic [31:0]      w_data_reg;
	logic [3:0]       w_strb_reg;
	logic             wr_fire;
	logic             slverr_next;
	// Handler state
	cmd_state_e       state_reg;
	task_cmd_s        cmd_reg;
	logic             frozen_reg;
	logic             locked_reg;
	logic             prep_done_reg;
	logic             aborted_reg;
	logic             busy;
	logic [8:0]       word_cnt_reg;
	logic             pw_sel_reg;
	logic             pw_match_reg;
	logic [15:0]      user_pw_reg [1:16];
	logic [15:0]      master_pw_reg [1:16];
	logic             user_set_reg;
	logic [7:0]       err_reg;
	logic [7:0]       last_code_reg;
	logic [7:0]       sect_cnt_reg;
	err_event_s       ev_reg;
	logic [5:0]       ev_ext_reg;    // Media and ECC events, EVENT bits 13:8
	logic [7:0]       ev_code;
	logic             cmd_wr;
	logic             data_wr;
	logic             dh_ok;
	logic [15:0]      wd;

	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign cmd_wr  = wr_fire && (aw_addr_reg == `ADDR_CMD) && (state_reg == ST_IDLE);
	assign data_wr = wr_fire && (aw_addr_reg == `ADDR_DATA) && (state_reg == ST_DATA);
	assign busy    = (state_reg != ST_IDLE);
	assign wd      = w_data_reg[15:0];
	// R22 drive/head check
	assign dh_ok   = w_data_reg[15] && w_data_reg[13];

	// Address and data accepted in either order, held until response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else if (ce) begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= slverr_next ? 2'b10 : 2'b00;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Unmapped address or write to the wrong place answers SLVERR
	always_comb begin
		if (aw_addr_reg == `ADDR_CMD) begin
			slverr_next = busy;
		end else if (aw_addr_reg == `ADDR_DATA) begin
			slverr_next = (state_reg != ST_DATA);
		end else if (aw_addr_reg == `ADDR_EVENT) begin
			slverr_next = 1'b0;
		end else if (aw_addr_reg == `ADDR_CTRL) begin
			slverr_next = 1'b0;
		end else begin
			slverr_next = 1'b1;
		end
	end

	// R02 R03 R04 R05 R06 R07 R08 event encoder
	// Events stay latched until the next sense or EVENT write; faults outrank self test passed, and all but misc outrank corrected data
	always_comb begin
		if (ev_reg.xfer_err) begin
			ev_code = `EC_ABORT;
		end else if (ev_reg.inv_addr) begin
			ev_code = `EC_INV_ADDR;
		end else if (ev_reg.overflow) begin
			ev_code = `EC_OVERFLOW;
		end else if (ev_reg.volt_sup) begin
			ev_code = `EC_VOLT_SUP;
		end else if (ev_reg.volt_gen) begin
			ev_code = `EC_VOLT_GEN;
		end else if (ev_reg.diag_fail) begin
			ev_code = `EC_DIAG;
		end else if (ev_ext_reg[0]) begin
			ev_code = `EC_UNCORR;
		end else if (ev_ext_reg[2]) begin
			ev_code = `EC_IDNF;
		end else if (ev_ext_reg[3]) begin
			ev_code = `EC_SPARES;
		end else if (ev_ext_reg[4]) begin
			ev_code = `EC_WR_FAIL;
		end else if (ev_ext_reg[5]) begin
			ev_code = `EC_MEDIA;
		end else if (ev_ext_reg[1]) begin
			ev_code = `EC_CORR;
		end else if (ev_reg.misc) begin
			ev_code = `EC_MISC;
		end else if (ev_reg.selftest_ok) begin
			ev_code = `EC_SELFTEST;
		end else begin
			ev_code = `EC_NONE;
		end
	end

	// Command state machine and security state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg     <= ST_IDLE;
			cmd_reg       <= '0;
			// R17 only reset clears frozen
			frozen_reg    <= 1'b0;
			locked_reg    <= 1'b0;
			prep_done_reg <= 1'b0;
			aborted_reg   <= 1'b0;
			word_cnt_reg  <= 9'd0;
			pw_sel_reg    <= 1'b0;
			pw_match_reg  <= 1'b1;
			user_set_reg  <= 1'b0;
			err_reg       <= 8'h00;
			last_code_reg <= `EC_NONE;
			sect_cnt_reg  <= 8'h00;
			ev_reg        <= '0;
			ev_ext_reg    <= 6'h00;
			wear_level_go <= 1'b0;
		end else if (ce) begin
			wear_level_go <= 1'b0;
			if (wr_fire && aw_addr_reg == `ADDR_EVENT) begin
				ev_reg     <= w_data_reg[7:0];
				ev_ext_reg <= w_data_reg[13:8];
			end
			if (wr_fire && aw_addr_reg == `ADDR_CTRL) begin
				sect_cnt_reg <= w_data_reg[7:0];
			end
			case (state_reg)
				ST_IDLE: begin
					if (cmd_wr) begin
						cmd_reg      <= {w_data_reg[15:8], w_data_reg[7:0]};
						word_cnt_reg <= 9'd0;
						pw_match_reg <= 1'b1;
						aborted_reg  <= 1'b0;
						// R14 prepare flag only survives into the very next command
						prep_done_reg <= 1'b0;
						if (!dh_ok) begin
							aborted_reg   <= 1'b1;
							last_code_reg <= `EC_ABORT;
						end else begin
							case (w_data_reg[7:0])
								// R01 sense returns previous command code
								`OP_SENSE: begin
									err_reg       <= (last_code_reg == `EC_NONE) ? ev_code : last_code_reg;
									last_code_reg <= `EC_NONE;
									ev_reg        <= '0;
									ev_ext_reg    <= 6'h00;
								end
								`OP_ERASE_PREP: begin
									prep_done_reg <= 1'b1;
									last_code_reg <= `EC_NONE;
								end
								// R15 R18 R20 freeze, or wear level without security
								`OP_FREEZE: begin
									if (sec_supported) begin
										frozen_reg <= 1'b1;
									end else begin
										wear_level_go <= 1'b1;
									end
									// R19 sector count cleared
									sect_cnt_reg  <= 8'h00;
									last_code_reg <= `EC_NONE;
								end
								// R16 frozen rejects lock-changing commands
								`OP_SET_PW, `OP_UNLOCK, `OP_DISABLE_PW, `OP_ERASE_UNIT: begin
									if (frozen_reg || !sec_supported ||
										(w_data_reg[7:0] == `OP_ERASE_UNIT && !prep_done_reg)) begin
										aborted_reg   <= 1'b1;
										last_code_reg <= `EC_ABORT;
									end else begin
										state_reg <= ST_DATA;
									end
								end
								default: begin
									aborted_reg   <= 1'b1;
									last_code_reg <= `EC_ABORT;
								end
							endcase
						end
					end
				end
				// R11 R21 one 256-word sector, word 0 selects password
				ST_DATA: begin
					if (data_wr) begin
						word_cnt_reg <= word_cnt_reg + 9'd1;
						if (word_cnt_reg == 9'd0) begin
							pw_sel_reg <= wd[`ID_BIT];
						end else if (word_cnt_reg <= `PW_LAST) begin
							if (cmd_reg.opcode == `OP_SET_PW) begin
								if (pw_sel_reg) begin
									master_pw_reg[word_cnt_reg[4:0]] <= wd;
								end else begin
									user_pw_reg[word_cnt_reg[4:0]] <= wd;
								end
							end else if ((pw_sel_reg ? master_pw_reg[word_cnt_reg[4:0]]
									: user_pw_reg[word_cnt_reg[4:0]]) != wd) begin
								pw_match_reg <= 1'b0;
							end
						end
						if (word_cnt_reg == `SECTOR_WORDS - 9'd1) begin
							state_reg <= ST_EXEC;
						end
					end
				end
				ST_EXEC: begin
					state_reg     <= ST_IDLE;
					last_code_reg <= `EC_NONE;
					case (cmd_reg.opcode)
						`OP_SET_PW: begin
							if (!pw_sel_reg) begin
								user_set_reg <= 1'b1;
								locked_reg   <= 1'b1;
							end
						end
						// R09 R10 matching password leaves lock; master kept
						`OP_DISABLE_PW, `OP_UNLOCK: begin
							if (pw_match_reg) begin
								locked_reg <= 1'b0;
								if (cmd_reg.opcode == `OP_DISABLE_PW) begin
									user_set_reg <= 1'b0;
								end
							end else begin
								aborted_reg   <= 1'b1;
								last_code_reg <= `EC_ABORT;
							end
						end
						// R13 mismatch aborts erase
						default: begin
							if (pw_match_reg) begin
								locked_reg   <= 1'b0;
								user_set_reg <= 1'b0;
							end else begin
								aborted_reg   <= 1'b1;
								last_code_reg <= `EC_ABORT;
							end
						end
					endcase
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Read channel, one word per request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else if (ce) begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				if (s_axi_araddr[7:0] == `ADDR_CMD) begin
					s_axi_rdata <= {16'h0000, cmd_reg};
				end else if (s_axi_araddr[7:0] == `ADDR_STATUS) begin
					s_axi_rdata <= {8'h00, sect_cnt_reg, err_reg, 1'b0, busy, user_set_reg,
						prep_done_reg, aborted_reg, locked_reg, frozen_reg, state_reg == ST_DATA};
				end else if (s_axi_araddr[7:0] == `ADDR_EVENT) begin
					s_axi_rdata <= {18'h0_0000, ev_ext_reg, ev_reg};
				end else if (s_axi_araddr[7:0] == `ADDR_CTRL) begin
					s_axi_rdata <= {24'h00_0000, sect_cnt_reg};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// R17 frozen never falls while out of reset
	a_frozen_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // R17
		$past(frozen_reg) && $past(aresetn) |-> frozen_reg)
		else $error("frozen cleared without reset");
	// R19 freeze clears sector count
	a_freeze_cnt_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R19
		ce && cmd_wr && dh_ok && w_data_reg[7:0] == `OP_FREEZE |=> sect_cnt_reg == 8'h00)
		else $error("sector count not zero after freeze");
	// R16 frozen blocks data phase
	a_frozen_reject: assert property (@(posedge aclk) disable iff (!aresetn) // R16
		frozen_reg && ce && cmd_wr |=> state_reg == ST_IDLE)
		else $error("frozen device accepted lock command");
	// R14 erase unit without prepare aborts
	a_erase_no_prep: assert property (@(posedge aclk) disable iff (!aresetn) // R14
		ce && cmd_wr && w_data_reg[7:0] == `OP_ERASE_UNIT && !prep_done_reg |=> aborted_reg)
		else $error("erase unit ran without prepare");
	// R20 wear level only without security
	a_wear_level: assert property (@(posedge aclk) disable iff (!aresetn) // R20
		ce && cmd_wr && dh_ok && w_data_reg[7:0] == `OP_FREEZE |=> wear_level_go != $past(sec_supported))
		else $error("wear level with security present");
	// R07 abort code
	a_abort_code: assert property (@(posedge aclk) disable iff (!aresetn) // R07
		ce && cmd_wr && !dh_ok |=> last_code_reg == `EC_ABORT && aborted_reg)
		else $error("abort code not recorded");
	// R01 sense loads error register
	a_sense_err: assert property (@(posedge aclk) disable iff (!aresetn) // R01
		ce && cmd_wr && dh_ok && w_data_reg[7:0] == `OP_SENSE && last_code_reg != `EC_NONE
		|=> err_reg == $past(last_code_reg))
		else $error("sense did not report previous code");
	// R13 mismatched erase aborts
	a_erase_mismatch: assert property (@(posedge aclk) disable iff (!aresetn) // R13
		ce && state_reg == ST_EXEC && cmd_reg.opcode == `OP_ERASE_UNIT && !pw_match_reg |=> aborted_reg)
		else $error("erase with wrong password not aborted");
	// R07 transfer error outranks every other pending event
	a_xfer_first: assert property (@(posedge aclk) disable iff (!aresetn) // R07
		ce && cmd_wr && dh_ok && w_data_reg[7:0] == `OP_SENSE && last_code_reg == `EC_NONE
		&& ev_reg.xfer_err |=> err_reg == `EC_ABORT)
		else $error("transfer error not reported first");
	// R14 prepare flag dies with any other command
	a_prep_once: assert property (@(posedge aclk) disable iff (!aresetn) // R14
		ce && cmd_wr && w_data_reg[7:0] != `OP_ERASE_PREP |=> !prep_done_reg)
		else $error("erase prepare outlived the next command");
endmodule // sec_sense_handler
`default_nettype wire

// *** inc/sec_sense_cfg.svh ***
// Constants for the security and sense command handler
// Functional notes
// R01: Sense request puts extended error code of previous command in error register.
// R02: Code 01h for self test passed, 09h for miscellaneous error.
// R03: Invalid head or sector reports code 21h.
// R04: Address beyond capacity reports code 2Fh.
// R05: Supply or internal voltage out of tolerance reports 35h or 36h.
// R06: Failed self test reports 05h, 30h-34h, 37h or 3Eh.
// R07: Transfer error or aborted command reports 1Fh.
// R08: Other codes: 00h, 11h, 18h, 10h/14h, 3Ah, 03h, media format codes.
// R09: Disable password takes one sector; matching selected password leaves lock mode.
// R10: Disable password leaves master password unchanged.
// R11: Word 0 bit 0 selects user/master; words 1-16 hold 32 byte password.
// R12: Host issues erase prepare directly before erase unit.
// R13: Erase unit takes one sector; aborts on password mismatch.
// R14: Erase unit aborts unless previous command was completed erase prepare.
// R15: Freeze lock enters frozen mode; later lock-changing commands are rejected.
// R16: Frozen device rejects set password, unlock, disable password, erase unit.
// R17: Frozen mode clears only on power removal or hardware reset.
// R18: Freeze lock while frozen completes normally, stays frozen.
// R19: Completed freeze lock sets sector count register to 0.
// R20: Without security feature set, F5h runs as wear level command.
// R21: Set password takes one sector whose contents define the action.
// R22: Drive/head needs bits 7 and 5 set; other task-file registers ignored.
`ifndef SEC_SENSE_CFG_SVH
`define SEC_SENSE_CFG_SVH
`define ADDR_CMD      8'h00
`define ADDR_STATUS   8'h04
`define ADDR_DATA     8'h08
`define ADDR_EVENT    8'h0C
`define ADDR_CTRL     8'h10
`define OP_SENSE      8'h03
`define OP_SET_PW     8'hF1
`define OP_UNLOCK     8'hF2
`define OP_ERASE_PREP 8'hF3
`define OP_ERASE_UNIT 8'hF4
`define OP_FREEZE     8'hF5
`define OP_DISABLE_PW 8'hF6
`define EC_NONE       8'h00
`define EC_SELFTEST   8'h01
`define EC_WR_FAIL    8'h03
`define EC_DIAG       8'h05
`define EC_MEDIA      8'h0C
`define EC_IDNF       8'h10
`define EC_UNCORR     8'h11
`define EC_CORR       8'h18
`define EC_ABORT      8'h1F
`define EC_MISC       8'h09
`define EC_INV_ADDR   8'h21
`define EC_OVERFLOW   8'h2F
`define EC_VOLT_SUP   8'h35
`define EC_VOLT_GEN   8'h36
`define EC_SPARES     8'h3A
`define SECTOR_WORDS  9'd256
`define PW_FIRST      9'd1
`define PW_LAST       9'd16
`define ID_BIT        0
`endif

// *** inc/sec_sense_pkg.sv ***
// Types for the security and sense command handler
package sec_sense_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DATA = 3'b001,
		ST_EXEC = 3'b010
	} cmd_state_e;
	typedef struct packed {
		logic [7:0] drive_head;
		logic [7:0] opcode;
	} task_cmd_s;
	typedef struct packed {
		logic diag_fail;
		logic volt_gen;
		logic volt_sup;
		logic overflow;
		logic inv_addr;
		logic xfer_err;
		logic misc;
		logic selftest_ok;
	} err_event_s;
endpackage

// *** sim/host_ctrl_model.sv ***
// Host disk controller model: AXI4-Lite master for the task file
`timescale 1ns/100ps
`default_nettype none
`include "sec_sense_cfg.svh"
module host_ctrl_model (
	input  wire logic        aclk,    // Bus clock
	output logic      [31:0] awaddr,  // Write address
	output logic             awvalid, // Write address valid
	input  wire logic        awready, // Write address ready
	output logic      [31:0] wdata,   // Write data
	output logic             wvalid,  // Write data valid
	input  wire logic        wready,  // Write data ready
	input  wire logic [1:0]  bresp,   // Write response
	input  wire logic        bvalid,  // Write response valid
	output logic             bready,  // Write response ready
	output logic      [31:0] araddr,  // Read address
	output logic             arvalid, // Read address valid
	input  wire logic        arready, // Read address ready
	input  wire logic [31:0] rdata,   // Read data
	input  wire logic [1:0]  rresp,   // Read response
	input  wire logic        rvalid,  // Read response valid
	output logic             rready   // Read response ready
);
	// Idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wvalid} = '0;
		{araddr, arvalid} = '0;
		// Response ready stays high, so back to back calls never toggle it in one step
		bready = 1'b1;
		rready = 1'b1;
	end
	// Released payload is inverted so stale values never pass for live ones
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (pa && awready) begin
				pa = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (pw && wready) begin
				pw = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid) begin
				r = bresp;
				break;
			end
		end
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic pa;
		pa = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (pa && arready) begin
				pa = 1'b0;
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
	endtask
	task automatic sector(input logic master, input logic [7:0] key);
		logic [1:0] r;
		for (int i = 0; i < 256; i++) begin
			if (i == 0) wr(`ADDR_DATA, {31'h0000_0000, master}, r);
			else if (i <= 16) wr(`ADDR_DATA, {16'h0000, key, key ^ i[7:0]}, r);
			else wr(`ADDR_DATA, 32'h0000_0000, r);
		end
	endtask
endmodule // host_ctrl_model
`default_nettype wire

// *** sim/sec_sense_handler_bench.sv ***
// Self-checking bench for the security and sense command handler
`timescale 1ns/100ps
`default_nettype none
`include "sec_sense_cfg.svh"
module sec_sense_handler_bench import sec_sense_pkg::*;;
	// drive/head bits 7 and 5 set
	localparam logic [7:0] DH = 8'hA0;
	logic aclk, aresetn, sec_supported, wear_level_go;
	logic [31:0] awaddr, wdata, araddr, rdata, s;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, r;
	logic [7:0] wear_cnt = 8'h00;
	logic ce = 1'b1;
	int error_cnt, checks_done, cyc, t0;
	logic [7:0] codes [14] = '{`EC_SELFTEST, `EC_MISC, `EC_ABORT, `EC_INV_ADDR,
		`EC_OVERFLOW, `EC_VOLT_SUP, `EC_VOLT_GEN, `EC_DIAG, `EC_UNCORR, `EC_CORR,
		`EC_IDNF, `EC_SPARES, `EC_WR_FAIL, `EC_MEDIA};
	logic [7:0] locks [4] = '{`OP_SET_PW, `OP_UNLOCK, `OP_DISABLE_PW, `OP_ERASE_UNIT};

	sec_sense_handler dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sec_supported(sec_supported),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .wear_level_go(wear_level_go));
	host_ctrl_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	// 100 ns clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// Wear pulses counted so a missing or doubled pulse shows
	always @(posedge aclk) begin
		if (wear_level_go === 1'b1) wear_cnt <= wear_cnt + 8'h01;
	end
	// Watchdog; whole run is near 6500 cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Polls until idle or waiting for the sector; busy may read X early
	task automatic poll(output logic [31:0] st);
		logic [1:0] rr;
		for (int i = 0; i < 64; i++) begin
			host_u.rd(`ADDR_STATUS, st, rr);
			if (st[6] !== 1'b1 || st[0] === 1'b1) break;
		end
	endtask
	task automatic secure(input logic [7:0] op, input logic [7:0] dh, input logic [7:0] key,
		output logic [31:0] st);
		logic [1:0] rr;
		host_u.wr(`ADDR_CMD, {16'h0000, dh, op}, rr);
		poll(st);
		if (st[0] === 1'b1) begin
			host_u.sector(1'b0, key);
			poll(st);
		end
	endtask
	task automatic sense(input logic [7:0] e);
		logic [31:0] st;
		secure(`OP_SENSE, DH, 8'h00, st);
		chk_byte("error code", e, st[15:8]);
	endtask

	initial begin
		aresetn = 1'b0;
		sec_supported = 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		host_u.rd(`ADDR_STATUS, s, r);
		chk_bit("frozen", 1'b0, s[1]);
		host_u.rd(32'h0000_0040, s, r);
		chk_byte("unmapped rresp", 8'h02, {6'h00, r});
		host_u.wr(`ADDR_DATA, 32'h0000_0000, r);
		chk_byte("data bresp", 8'h02, {6'h00, r});
		$display("test reset done");
		for (int i = 0; i < 14; i++) begin
			host_u.wr(`ADDR_EVENT, 32'h0000_0001 << i, r);
			sense(codes[i]);
		end
		host_u.wr(`ADDR_EVENT, 32'h0000_0006, r);
		sense(`EC_ABORT);
		sense(`EC_NONE);
		secure(`OP_ERASE_PREP, 8'h00, 8'h00, s);
		sense(`EC_ABORT);
		$display("test sense codes done");
		secure(`OP_SET_PW, DH, 8'h5A, s);
		chk_bit("locked", 1'b1, s[2]);
		secure(`OP_DISABLE_PW, DH, 8'hA5, s);
		chk_bit("locked", 1'b1, s[2]);
		secure(`OP_DISABLE_PW, DH, 8'h5A, s);
		chk_bit("locked", 1'b0, s[2]);
		$display("test passwords done");
		secure(`OP_SET_PW, DH, 8'h5A, s);
		secure(`OP_ERASE_UNIT, DH, 8'h5A, s);
		chk_bit("aborted", 1'b1, s[3]);
		sense(`EC_ABORT);
		secure(`OP_ERASE_PREP, DH, 8'h00, s);
		chk_bit("prep done", 1'b1, s[4]);
		secure(`OP_ERASE_UNIT, DH, 8'hA5, s);
		chk_bit("aborted", 1'b1, s[3]);
		secure(`OP_ERASE_PREP, DH, 8'h00, s);
		sense(`EC_NONE);
		secure(`OP_ERASE_UNIT, DH, 8'h5A, s);
		chk_bit("aborted", 1'b1, s[3]);
		secure(`OP_ERASE_PREP, DH, 8'h00, s);
		secure(`OP_ERASE_UNIT, DH, 8'h5A, s);
		chk_bit("aborted", 1'b0, s[3]);
		$display("test erase done");
		host_u.wr(`ADDR_CTRL, 32'h0000_0007, r);
		chk_byte("ctrl bresp", 8'h00, {6'h00, r});
		// Clock enable low must stall the read until it rises again
		ce <= 1'b0;
		t0 = cyc;
		fork
			begin
				repeat (8) @(posedge aclk);
				ce <= 1'b1;
			end
			host_u.rd(`ADDR_CTRL, s, r);
		join
		chk_bit("ce stall", 1'b1, (cyc - t0) >= 8);
		chk_byte("sector count", 8'h07, s[7:0]);
		secure(`OP_FREEZE, DH, 8'h00, s);
		chk_bit("frozen", 1'b1, s[1]);
		chk_byte("sector count", 8'h00, s[23:16]);
		for (int i = 0; i < 4; i++) begin
			secure(locks[i], DH, 8'h5A, s);
			chk_bit("aborted", 1'b1, s[3]);
		end
		secure(`OP_FREEZE, DH, 8'h00, s);
		chk_bit("aborted", 1'b0, s[3]);
		chk_bit("frozen", 1'b1, s[1]);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		host_u.rd(`ADDR_STATUS, s, r);
		chk_bit("frozen", 1'b0, s[1]);
		$display("test freeze done");
		sec_supported <= 1'b0;
		secure(`OP_FREEZE, DH, 8'h00, s);
		chk_bit("frozen", 1'b0, s[1]);
		chk_byte("wear pulses", 8'h01, wear_cnt);
		$display("test wear level done");
		give_verdict();
	end
endmodule // sec_sense_handler_bench
`default_nettype wire
